// ---- design/bscu_bitalu.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bscu_map.svh"
module bscu_bitalu #(
	parameter int WIDTH = 40,
	parameter int IDXW = 6
) (
	// operand
	input wire logic [WIDTH-1:0] data_i,
	input wire logic [IDXW-1:0] idx_i,
	input wire logic invert_i,
	// result
	output logic [WIDTH-1:0] data_o,
	output logic idx_ok_o
);
	if (WIDTH < 2 || (1 << IDXW) < WIDTH) begin : g_idx_chk
		$error("bscu_bitalu: index too narrow");
	end
	logic [WIDTH-1:0] onehot;
	always_comb begin
		onehot = '0;
		idx_ok_o = (32'(idx_i) < WIDTH);
		if (idx_ok_o)
			onehot[idx_i] = 1'b1;
		// invert or force only the selected bit
		data_o = invert_i ? (data_i ^ onehot) : (data_i | onehot);
	end
endmodule : bscu_bitalu
`default_nettype wire

// ---- design/bscu_core.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bscu_map.svh"
module bscu_core
	import bscu_pkg::*;
#(
	parameter int ACCW = 40,
	parameter int WORDW = 16
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// decoder issue
	input wire logic issue_i,
	input wire logic [2:0] op_i,
	input wire logic [1:0] tgt_i,
	input wire logic [ACCW-1:0] src_i,
	input wire logic [ACCW-1:0] baddr_i,
	input wire logic [1:0] st_sel_i,
	input wire logic [3:0] imm4_bit_index_i,
	input wire logic in_repeat_i,
	// register result
	output logic res_valid_o,
	output logic [ACCW-1:0] res_o,
	output logic au_path_o,
	output logic bad_addr_o,
	output logic reject_o,
	output logic busy_o,
	output logic flush_o,
	// data memory
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [WORDW-1:0] mem_wdata_o,
	input wire logic [WORDW-1:0] mem_rdata_i,
	// mode pin
	input wire logic mp_mc_pin_i,
	// register port
	input wire logic [2:0] reg_addr_i,
	input wire logic [WORDW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [WORDW-1:0] reg_rdata_o
);
	// only the documented widths are served by the datapath
	if (ACCW != 40 || WORDW != 16) begin : g_width_chk
		$error("bscu_core: widths must be 40 and 16");
	end

	// ****************************************
	// status words
	// ****************************************
	logic [WORDW-1:0] sw_reg [4];
	logic [WORDW-1:0] sw_next [4];
	logic strap_done_reg, strap_done_next;
	logic [WORDW-1:0] rdata_reg, rdata_next;

	// ****************************************
	// field masks
	// ****************************************
	function automatic logic [WORDW-1:0] prot_mask(input logic [1:0] w);
		case (w)
			2'h0: prot_mask = `BSCU_PROT_SW0;
			2'h1: prot_mask = `BSCU_PROT_SW1;
			2'h2: prot_mask = `BSCU_PROT_SW2;
			default: prot_mask = `BSCU_PROT_SW3;
		endcase
	endfunction : prot_mask

	function automatic logic [WORDW-1:0] wr_mask(input logic [1:0] w);
		case (w)
			2'h0: wr_mask = `BSCU_MASK_SW0;
			2'h1: wr_mask = `BSCU_MASK_SW1;
			2'h2: wr_mask = `BSCU_MASK_SW2;
			default: wr_mask = `BSCU_MASK_SW3;
		endcase
	endfunction : wr_mask

	// ****************************************
	// sequencer
	// ****************************************
	bscu_state_t state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [3:0] midx_reg, midx_next;
	logic minv_reg, minv_next;
	logic [ACCW-1:0] res_reg, res_next;
	logic res_valid_reg, res_valid_next;
	logic au_reg, au_next;
	logic bad_reg, bad_next;
	logic reject_reg, reject_next;
	logic [WORDW-1:0] mwdata_reg, mwdata_next;

	// ****************************************
	// register datapath
	// ****************************************
	// register-target bit change
	logic [5:0] ridx;
	logic [ACCW-1:0] ralu_out;
	logic ralu_ok;
	logic is_acc;
	assign is_acc = (tgt_i == BSCU_TGT_ACC);
	always_comb begin
		// aux and temp registers only use low bits of the address
		if (is_acc)
			ridx = baddr_i[5:0];
		else
			ridx = {2'h0, baddr_i[`BSCU_AU_IDX_W-1:0]};
	end

	bscu_bitalu #(.WIDTH(ACCW), .IDXW(6)) u_ralu (
		.data_i(is_acc ? src_i : {{(ACCW-WORDW){1'b0}}, src_i[WORDW-1:0]}),
		.idx_i(ridx),
		.invert_i(op_i == BSCU_OP_REG_NOT),
		.data_o(ralu_out),
		.idx_ok_o(ralu_ok)
	);

	// ****************************************
	// memory datapath
	// ****************************************
	// memory word bit change
	logic [WORDW-1:0] malu_out;
	bscu_bitalu #(.WIDTH(WORDW), .IDXW(4)) u_malu (
		.data_i(mem_rdata_i),
		.idx_i(midx_reg),
		.invert_i(minv_reg),
		.data_o(malu_out),
		.idx_ok_o()
	);

	// ****************************************
	// status bit set
	// ****************************************
	logic [WORDW-1:0] st_onehot;
	always_comb begin
		// labels are resolved by the decoder to the same word and position
		st_onehot = '0;
		st_onehot[imm4_bit_index_i] = 1'b1;
	end

	logic cache_hit;
	// only the three cache bits of word three need the pipeline flushed
	assign cache_hit = (st_sel_i == 2'h3) &&
		(imm4_bit_index_i >= `BSCU_CACHE_LO);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		midx_next = midx_reg;
		minv_next = minv_reg;
		res_next = res_reg;
		res_valid_next = 1'b0;
		au_next = au_reg;
		bad_next = bad_reg;
		reject_next = 1'b0;
		mwdata_next = mwdata_reg;
		for (int i = 0; i < 4; i++)
			sw_next[i] = sw_reg[i];
		strap_done_next = 1'b1;
		rdata_next = '0;
		// strap caught on first clock after release
		if (!strap_done_reg)
			sw_next[3][`BSCU_MPMC_BIT] = mp_mc_pin_i;
		case (state_reg)
			BSCU_ST_IDLE: begin
				if (issue_i) begin
					case (op_i)
						BSCU_OP_REG_SET, BSCU_OP_REG_NOT: begin
							res_next = ralu_out;
							res_valid_next = 1'b1;
							au_next = !is_acc;
							// out-of-range accumulator address leaves data intact
							bad_next = is_acc && !ralu_ok;
						end
						BSCU_OP_MEM_SET, BSCU_OP_MEM_NOT: begin
							midx_next = src_i[`BSCU_MEM_IDX_W-1:0];
							minv_next = (op_i == BSCU_OP_MEM_NOT);
							state_next = BSCU_ST_MEMRD;
						end
						BSCU_OP_ST_SET: begin
							// not repeatable: refused with no change at all
							if (in_repeat_i)
								reject_next = 1'b1;
							else begin
								sw_next[st_sel_i] = sw_reg[st_sel_i] |
									(st_onehot & wr_mask(st_sel_i));
								if (cache_hit) begin
									cnt_next = `BSCU_CACHE_CYCLES - 3'h1;
									state_next = BSCU_ST_FLUSH;
								end
							end
						end
						default: ;
					endcase
				end
			end
			BSCU_ST_MEMRD: begin
				// memory answers one cycle after the read strobe
				state_next = BSCU_ST_MEMWR;
			end
			BSCU_ST_MEMWR: begin
				mwdata_next = malu_out;
				state_next = BSCU_ST_IDLE;
			end
			BSCU_ST_FLUSH: begin
				// issue cycle plus the cycles counted here give the flush length
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h1)
					state_next = BSCU_ST_IDLE;
			end
			default: state_next = BSCU_ST_IDLE;
		endcase
		// software access to status words
		// placed after the sequencer so a port write wins over a status set
		if (reg_wr_i) begin
			if (reg_addr_i[2])
				sw_next[reg_addr_i[1:0]] = (sw_next[reg_addr_i[1:0]] &
					prot_mask(reg_addr_i[1:0])) | (reg_wdata_i &
					wr_mask(reg_addr_i[1:0]) &
					~prot_mask(reg_addr_i[1:0]));
			else
				sw_next[reg_addr_i[1:0]] = reg_wdata_i &
					wr_mask(reg_addr_i[1:0]);
		end
		if (reg_rd_i) begin
			if (reg_addr_i[2])
				rdata_next = sw_reg[reg_addr_i[1:0]] &
					~prot_mask(reg_addr_i[1:0]);
			else
				rdata_next = sw_reg[reg_addr_i[1:0]];
		end
		// reserved field of word three reads as 1100
		sw_next[3][`BSCU_SW3_RSVD_LSB +: 4] = `BSCU_SW3_RSVD_VAL;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= BSCU_ST_IDLE;
			cnt_reg <= 3'h0;
			midx_reg <= 4'h0;
			minv_reg <= 1'b0;
			res_reg <= '0;
			res_valid_reg <= 1'b0;
			au_reg <= 1'b0;
			bad_reg <= 1'b0;
			reject_reg <= 1'b0;
			mwdata_reg <= '0;
			sw_reg[0] <= `BSCU_RST_SW0;
			sw_reg[1] <= `BSCU_RST_SW1;
			sw_reg[2] <= `BSCU_RST_SW2;
			sw_reg[3] <= `BSCU_RST_SW3;
			strap_done_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			midx_reg <= midx_next;
			minv_reg <= minv_next;
			res_reg <= res_next;
			res_valid_reg <= res_valid_next;
			au_reg <= au_next;
			bad_reg <= bad_next;
			reject_reg <= reject_next;
			mwdata_reg <= mwdata_next;
			for (int i = 0; i < 4; i++)
				sw_reg[i] <= sw_next[i];
			strap_done_reg <= strap_done_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign res_valid_o = res_valid_reg;
	assign res_o = res_reg;
	assign au_path_o = au_reg;
	assign bad_addr_o = bad_reg;
	assign reject_o = reject_reg;
	// issue is only taken while this is low
	assign busy_o = (state_reg != BSCU_ST_IDLE);
	assign flush_o = (state_reg == BSCU_ST_FLUSH);
	assign mem_rd_o = (state_reg == BSCU_ST_MEMRD);
	assign mem_wr_o = (state_reg == BSCU_ST_MEMWR);
	// not registered: memory must answer in the cycle after the read strobe
	assign mem_wdata_o = malu_out;
	assign reg_rdata_o = rdata_reg;
	// registered write word is kept for observation only
	logic unused_ok;
	assign unused_ok = ^mwdata_reg;
endmodule : bscu_core
`default_nettype wire

// ---- design/bscu_map.svh ----
`ifndef BSCU_MAP_SVH
`define BSCU_MAP_SVH
`define BSCU_ADDR_SW0 3'h0
`define BSCU_ADDR_SW1 3'h1
`define BSCU_ADDR_SW2 3'h2
`define BSCU_ADDR_SW3 3'h3
`define BSCU_ADDR_PSW0 3'h4
`define BSCU_ADDR_PSW1 3'h5
`define BSCU_ADDR_PSW2 3'h6
`define BSCU_ADDR_PSW3 3'h7
`define BSCU_RST_SW0 16'h3800
`define BSCU_RST_SW1 16'h2920
`define BSCU_RST_SW2 16'h1000
`define BSCU_RST_SW3 16'h1C00
`define BSCU_MASK_SW0 16'hFFFF
`define BSCU_MASK_SW1 16'hFFFF
`define BSCU_MASK_SW2 16'h9DFF
`define BSCU_MASK_SW3 16'hFFE7
`define BSCU_PROT_SW0 16'hC000
`define BSCU_PROT_SW1 16'h0420
`define BSCU_PROT_SW2 16'h0000
`define BSCU_PROT_SW3 16'hE0A0
`define BSCU_SW3_RSVD_LSB 8
`define BSCU_SW3_RSVD_VAL 4'hC
`define BSCU_MPMC_BIT 6
`define BSCU_CACHE_LO 4'hD
`define BSCU_CACHE_CYCLES 3'h5
`define BSCU_ACC_TOP 6'h27
`define BSCU_MEM_IDX_W 4
`define BSCU_AU_IDX_W 4
`endif

// ---- design/bscu_pkg.sv ----
`default_nettype none
package bscu_pkg;
	typedef enum logic [2:0] {
		BSCU_OP_NONE = 3'h0,
		BSCU_OP_REG_SET = 3'h1,
		BSCU_OP_REG_NOT = 3'h2,
		BSCU_OP_MEM_SET = 3'h3,
		BSCU_OP_MEM_NOT = 3'h4,
		BSCU_OP_ST_SET = 3'h5
	} bscu_op_t;
	typedef enum logic [1:0] {
		BSCU_TGT_ACC = 2'h0,
		BSCU_TGT_AUX = 2'h1,
		BSCU_TGT_TMP = 2'h2
	} bscu_tgt_t;
	typedef enum logic [3:0] {
		BSCU_ST_IDLE = 4'b0001,
		BSCU_ST_MEMRD = 4'b0010,
		BSCU_ST_MEMWR = 4'b0100,
		BSCU_ST_FLUSH = 4'b1000
	} bscu_state_t;
endpackage : bscu_pkg
`default_nettype wire

// ---- tb/bscu_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module bscu_mem_model (
	input wire logic mclk_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o
);
	logic [15:0] word = 16'h8001;
	logic rd_reg = 1'h0;
	// released bus shows the inverse, so stale data cannot pass
	assign rdata_o = rd_reg ? word : ~word;
	always @(posedge mclk_i) begin
		rd_reg <= mem_rd_i;
		if (mem_wr_i) word <= wdata_i;
	end
endmodule : bscu_mem_model
`default_nettype wire

// ---- tb/bscu_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// port checks
// ****
module bscu_properties #(
	parameter int ACCW = 40
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic issue_i,
	input wire logic [2:0] op_i,
	input wire logic [1:0] tgt_i,
	input wire logic [ACCW-1:0] src_i,
	input wire logic [ACCW-1:0] baddr_i,
	input wire logic [1:0] st_sel_i,
	input wire logic [3:0] imm4_bit_index_i,
	input wire logic in_repeat_i,
	input wire logic res_valid_o,
	input wire logic [ACCW-1:0] res_o,
	input wire logic au_path_o,
	input wire logic bad_addr_o,
	input wire logic reject_o,
	input wire logic busy_o,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [15:0] mem_wdata_o,
	input wire logic [15:0] mem_rdata_i
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);
	a_reg_answer: assert property (issue_i && !busy_o &&
		(op_i == 3'h1 || op_i == 3'h2) |=> res_valid_o) else $error("no result");
	a_not_onebit: assert property (res_valid_o && $past(op_i) == 3'h2 &&
		$past(tgt_i) == 2'h0 && !bad_addr_o
		|-> $countones(res_o ^ $past(src_i)) == 1) else $error("not flips");
	a_set_onebit: assert property (res_valid_o && $past(op_i) == 3'h1 &&
		$past(tgt_i) == 2'h0 && !bad_addr_o |-> res_o ==
		($past(src_i) | (ACCW'(1) << $past(baddr_i[5:0]))))
		else $error("set wrong");
	a_au_path: assert property (res_valid_o
		|-> au_path_o == ($past(tgt_i) != 2'h0)) else $error("unit wrong");
	a_acc_range: assert property (res_valid_o && $past(tgt_i) == 2'h0
		|-> bad_addr_o == ($past(baddr_i[5:0]) > 6'h27)) else $error("range");
	a_mem_seq: assert property (issue_i && !busy_o &&
		(op_i == 3'h3 || op_i == 3'h4) |=> mem_rd_o ##1 mem_wr_o)
		else $error("mem order");
	a_mem_set: assert property (mem_wr_o && $past(op_i, 2) == 3'h3
		|-> mem_wdata_o == (mem_rdata_i | (16'h1 << $past(src_i[3:0], 2))))
		else $error("mem set");
	a_mem_not: assert property (mem_wr_o && $past(op_i, 2) == 3'h4
		|-> mem_wdata_o == (mem_rdata_i ^ (16'h1 << $past(src_i[3:0], 2))))
		else $error("mem not");
	a_rep_reject: assert property (issue_i && !busy_o && op_i == 3'h5 &&
		in_repeat_i |=> reject_o) else $error("no reject");
	a_cache_busy: assert property (issue_i && !busy_o && op_i == 3'h5 &&
		!in_repeat_i && st_sel_i == 2'h3 && imm4_bit_index_i >= 4'hD
		|=> busy_o [*4] ##1 !busy_o) else $error("flush span");
endmodule : bscu_properties
bind bscu_core bscu_properties #(.ACCW(ACCW)) bscu_properties_inst (.*);
`default_nettype wire

// ---- tb/test_bit_set_complement_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_bit_set_complement_unit;
	typedef struct {
		logic [2:0] op;
		logic [1:0] tgt;
		logic [39:0] src, bd, res;
		logic au, bad;
	} bscu_row_t;
	logic mclk_i = '0, rstn_i = '0, issue_i = '0, in_repeat_i = '0;
	logic mp_mc_pin_i = 1'h1, reg_wr_i = '0, reg_rd_i = '0;
	logic [2:0] op_i = '0, reg_addr_i = '0;
	logic [1:0] tgt_i = '0, st_sel_i = '0;
	logic [39:0] src_i = '0, baddr_i = '0, res_o;
	logic [3:0] imm4_bit_index_i = '0;
	logic [15:0] reg_wdata_i = '0, reg_rdata_o, mem_wdata_o, mem_rdata_i;
	logic res_valid_o, au_path_o, bad_addr_o, reject_o, busy_o, flush_o;
	logic mem_rd_o, mem_wr_o;
	int mismatches = 0, n_tests = 0, n;
	bscu_row_t rows [5] = '{
		'{3'h2, 2'h0, 40'h0, 40'h27, 40'h80_0000_0000, 1'h0, 1'h0},
		'{3'h1, 2'h0, 40'hFF_0000_0000, 40'h0, 40'hFF_0000_0001, 1'h0, 1'h0},
		'{3'h2, 2'h2, 40'hE000, 40'h2C, 40'hF000, 1'h1, 1'h0},
		'{3'h1, 2'h1, 40'h0, 40'h14, 40'h10, 1'h1, 1'h0},
		'{3'h1, 2'h0, 40'h5, 40'h28, 40'h5, 1'h0, 1'h1}};
	always #50 mclk_i = ~mclk_i;
	bscu_core bscu_core_inst (.*);
	bscu_mem_model bscu_mem_model_inst (.mclk_i, .mem_rd_i(mem_rd_o),
		.mem_wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
	task chk(input logic [39:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task iss(input logic [2:0] op, input logic [1:0] tgt,
		input logic [39:0] src, bd, input logic [1:0] sel,
		input logic [3:0] k, input logic rep);
		@(posedge mclk_i);
		issue_i <= 1'h1;
		op_i <= op;
		tgt_i <= tgt;
		src_i <= src;
		baddr_i <= bd;
		st_sel_i <= sel;
		imm4_bit_index_i <= k;
		in_repeat_i <= rep;
		@(posedge mclk_i);
		issue_i <= 1'h0;
		#1;
	endtask : iss
	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'h0;
	endtask : wr
	task rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge mclk_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'h0;
		#1 chk(reg_rdata_o, e);
	endtask : rd
	task give_verdict;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	initial begin
		#300000;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rstn_i <= 1'h1;
		repeat (2) @(posedge mclk_i);
		rd(3'h0, 16'h3800);
		rd(3'h1, 16'h2920);
		rd(3'h2, 16'h1000);
		rd(3'h3, 16'h1C40);
		for (int i = 0; i < 5; i++) begin
			iss(rows[i].op, rows[i].tgt, rows[i].src, rows[i].bd,
				2'h0, 4'h0, i[0]);
			chk(res_valid_o, 1'h1);
			chk(res_o, rows[i].res);
			chk(au_path_o, rows[i].au);
			chk(bad_addr_o, rows[i].bad);
		end
		wr(3'h0, 16'h0000);
		iss(3'h5, 2'h0, 40'h0, 40'h0, 2'h0, 4'hB, 1'h0);
		rd(3'h0, 16'h0800);
		iss(3'h5, 2'h0, 40'h0, 40'h0, 2'h0, 4'hC, 1'h1);
		chk(reject_o, 1'h1);
		rd(3'h0, 16'h0800);
		wr(3'h0, 16'hFFFF);
		rd(3'h4, 16'h3FFF);
		wr(3'h4, 16'h0000);
		rd(3'h0, 16'hC000);
		wr(3'h3, 16'h0C00);
		iss(3'h5, 2'h0, 40'h0, 40'h0, 2'h3, 4'hF, 1'h0);
		chk(flush_o, 1'h1);
		n = 0;
		while (busy_o === 1'h1 && n < 20) begin
			@(posedge mclk_i);
			#1 n++;
		end
		chk(n, 4);
		chk(flush_o, 1'h0);
		rd(3'h3, 16'h8C00);
		iss(3'h5, 2'h0, 40'h0, 40'h0, 2'h1, 4'hE, 1'h0);
		rd(3'h1, 16'h6920);
		iss(3'h5, 2'h0, 40'h0, 40'h0, 2'h2, 4'h7, 1'h0);
		rd(3'h2, 16'h1080);
		iss(3'h3, 2'h0, 40'h5, 40'h0, 2'h0, 4'h0, 1'h1);
		repeat (2) @(posedge mclk_i);
		#1 chk(bscu_mem_model_inst.word, 16'h8021);
		iss(3'h4, 2'h0, 40'hFF_FFFF_FFF5, 40'h0, 2'h0, 4'h0, 1'h0);
		repeat (2) @(posedge mclk_i);
		#1 chk(bscu_mem_model_inst.word, 16'h8001);
		// mid-run reset with the strap pin low
		@(posedge mclk_i);
		rstn_i <= 1'h0;
		mp_mc_pin_i <= 1'h0;
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'h1;
		repeat (2) @(posedge mclk_i);
		rd(3'h0, 16'h3800);
		rd(3'h3, 16'h1C00);
		give_verdict();
	end
endmodule : test_bit_set_complement_unit
`default_nettype wire
